/* File: rtl/gfs_defs.svh */
// Register offsets, field positions, reset values and widths of the fault status bank
`ifndef GFS_DEFS_SVH
`define GFS_DEFS_SVH

`define GFS_ADDR_W 7
`define GFS_DATA_W 16
`define GFS_OFS_OVERCURRENT 7'h01
`define GFS_OFS_GATE_FAULT 7'h02
`define GFS_OFS_SUPPLY 7'h03
`define GFS_RST_STATUS 16'h0000
`define GFS_CNT_W 8
`define GFS_BIT_CYCLE_ACTIVE 15
`define GFS_POS_SENSE_OC 8
`define GFS_POS_DS_OC 0
`define GFS_POS_GATE_FAULT 0
`define GFS_POS_SUPPLY 8
`define GFS_POS_BOOTSTRAP 0

`endif

/* File: rtl/gfs_pkg.sv */
// Types shared by the fault status bank
package gfs_pkg;

  // One bit per MOSFET: A high, A low, B high, B low, C high, C low
  typedef logic [5:0] gfs_mosfet_t;

  typedef struct packed {
    logic [2:0] sense_resistor_overcurrent;  // A, B, C
    gfs_mosfet_t drain_source_overcurrent;
    gfs_mosfet_t gate_fault;
    logic [7:0] supply;     // power OV/UV, drain OV/UV, pump OV/UV, gate OV/UV
    logic [5:0] bootstrap;  // A OV/UV, B OV/UV, C OV/UV
  } gfs_detect_s;

  typedef struct packed {
    logic [6:0] addr;
    logic read_write_bit;  // 1 = read
    logic valid;
  } gfs_access_s;

endpackage : gfs_pkg

/* File: rtl/gfs_status_bank.sv */
// Fault status register bank of a three-phase gate driver
// Overview of operation
// - With cycle limiting on, the event counter steps up once, up to all ones, in each cycle where a drain-source or sense-resistor overcurrent detector rises.
// - Overcurrent status bit 15 reads 1 while the event counter is nonzero and 0 when it is zero.
// - Overcurrent status bits 10, 9, 8 flag sense-resistor overcurrent on phases A, B, C; bits 14-11 and 7-6 read zero.
// - Overcurrent status bits 5-0 flag drain-source overcurrent for A high, A low, B high, B low, C high, C low.
// - Gate fault status bits 5-0 flag gate faults in the same MOSFET order; bits 15-6 read zero.
// - Supply status bits 15-8 report power, drain-sense, charge-pump and gate-supply over- then undervoltage.
// - Supply status bits 5-0 report bootstrap over- then undervoltage for phases A, B, C; bits 7-6 read zero.
// - The three registers sit at addresses 1, 2 and 3, are read-only and reset to zero.
// - The summary drain-source overcurrent bit is the OR of the six per-MOSFET drain-source flags.
`timescale 1ns/1ps
`default_nettype none
`include "gfs_defs.svh"

module gfs_status_bank #(
  parameter int CNT_W = `GFS_CNT_W
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Detector levels and configuration
  input wire gfs_pkg::gfs_detect_s detect,
  input wire logic cycle_limit_enable,
  input wire logic cycle_counter_clear,
  // Decoded serial access
  input wire gfs_pkg::gfs_access_s access,
  // Read answer, counter activity and summary flag
  output logic [`GFS_DATA_W-1:0] read_data,
  output logic read_hit,
  output logic cycle_counter_active,
  output logic summary_ds_overcurrent
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // True for the three addresses this bank answers
  function automatic logic is_status_addr(
    input logic [`GFS_ADDR_W-1:0] a
  );
    is_status_addr = (a == `GFS_OFS_OVERCURRENT) ||
                     (a == `GFS_OFS_GATE_FAULT) ||
                     (a == `GFS_OFS_SUPPLY);
  endfunction : is_status_addr

  // A decoded frame that asks for read data
  function automatic logic is_read(input gfs_pkg::gfs_access_s acc);
    is_read = acc.valid && acc.read_write_bit;
  endfunction : is_read

  // Overcurrent word: counter activity, sense per phase, drain per MOSFET
  function automatic logic [`GFS_DATA_W-1:0] pack_overcurrent(
    input logic active,
    input gfs_pkg::gfs_detect_s d
  );
    logic [`GFS_DATA_W-1:0] w;
    w = `GFS_RST_STATUS;
    w[`GFS_BIT_CYCLE_ACTIVE] = active;
    w[`GFS_POS_SENSE_OC +: 3] = d.sense_resistor_overcurrent;
    w[`GFS_POS_DS_OC +: 6] = d.drain_source_overcurrent;
    pack_overcurrent = w;
  endfunction : pack_overcurrent

  // Gate fault word: per-MOSFET flags, upper bits stay zero
  function automatic logic [`GFS_DATA_W-1:0] pack_gate_fault(
    input gfs_pkg::gfs_detect_s d
  );
    logic [`GFS_DATA_W-1:0] w;
    w = `GFS_RST_STATUS;
    w[`GFS_POS_GATE_FAULT +: 6] = d.gate_fault;
    pack_gate_fault = w;
  endfunction : pack_gate_fault

  // Supply word: rails in the upper byte, bootstrap in the low six bits
  function automatic logic [`GFS_DATA_W-1:0] pack_supply(
    input gfs_pkg::gfs_detect_s d
  );
    logic [`GFS_DATA_W-1:0] w;
    w = `GFS_RST_STATUS;
    w[`GFS_POS_SUPPLY +: 8] = d.supply;
    w[`GFS_POS_BOOTSTRAP +: 6] = d.bootstrap;
    pack_supply = w;
  endfunction : pack_supply

  // Word returned for an address; anything unmapped reads as zero
  function automatic logic [`GFS_DATA_W-1:0] status_word(
    input logic [`GFS_ADDR_W-1:0] a,
    input logic active,
    input gfs_pkg::gfs_detect_s d
  );
    logic [`GFS_DATA_W-1:0] w;
    w = `GFS_RST_STATUS;
    unique case (a)
      `GFS_OFS_OVERCURRENT: begin
        w = pack_overcurrent(active, d);
      end
      `GFS_OFS_GATE_FAULT: begin
        w = pack_gate_fault(d);
      end
      `GFS_OFS_SUPPLY: begin
        w = pack_supply(d);
      end
      default: begin
        w = `GFS_RST_STATUS;
      end
    endcase
    status_word = w;
  endfunction : status_word

  ////////////////////////////////////////////////////////////////////////////
  // Detector latch

  // The serial side has no path into this copy, so a write frame can
  // never disturb a status bit.
  gfs_pkg::gfs_detect_s det_q;
  gfs_pkg::gfs_detect_s det_d;

  always_comb begin
    det_d = detect;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      det_q <= '0;
    end else if (clk_en) begin
      det_q <= det_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent event detection

  localparam int EVT_W = $bits(detect.sense_resistor_overcurrent) +
                         $bits(detect.drain_source_overcurrent);

  logic [EVT_W-1:0] oc_now;
  logic [EVT_W-1:0] oc_seen;
  logic [EVT_W-1:0] oc_rise;
  logic oc_event;

  assign oc_now = {detect.sense_resistor_overcurrent,
                   detect.drain_source_overcurrent};
  assign oc_seen = {det_q.sense_resistor_overcurrent,
                    det_q.drain_source_overcurrent};

  // Only a rising detector counts, so a fault held for many cycles is
  // one event rather than one per clock
  for (genvar i = 0; i < EVT_W; i++) begin : g_rise
    assign oc_rise[i] = oc_now[i] & ~oc_seen[i];
  end

  assign oc_event = |oc_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Event counter

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic active_q;
  logic active_d;

  // A clear and a new event in one cycle leave a count of one, as the
  // event is the newer of the two. Saturation keeps a long burst from
  // wrapping to zero and hiding the activity bit.
  always_comb begin
    cnt_d = cnt_q;
    if (!cycle_limit_enable || cycle_counter_clear) begin
      cnt_d = '0;
    end
    if (cycle_limit_enable && oc_event && (cnt_d != '1)) begin
      cnt_d = cnt_d + CNT_W'(1);
    end
    active_d = (cnt_d != '0);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      active_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      active_q <= active_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [`GFS_DATA_W-1:0] rdata_q;
  logic [`GFS_DATA_W-1:0] rdata_d;
  logic hit_q;
  logic hit_d;

  // The word is built from the latched copy, so a detector change shows
  // in read data two cycles later. The word holds between reads so the
  // serial shifter may take it at leisure.
  always_comb begin
    rdata_d = rdata_q;
    hit_d = 1'b0;
    if (is_read(access)) begin
      hit_d = is_status_addr(access.addr);
      rdata_d = status_word(access.addr, active_q, det_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= `GFS_RST_STATUS;
      hit_q <= 1'b0;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summary drain-source flag

  logic ds_sum_q;
  logic ds_sum_d;

  always_comb begin
    ds_sum_d = |det_d.drain_source_overcurrent;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ds_sum_q <= 1'b0;
    end else if (clk_en) begin
      ds_sum_q <= ds_sum_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign read_data = rdata_q;
  assign read_hit = hit_q;
  assign cycle_counter_active = active_q;
  assign summary_ds_overcurrent = ds_sum_q;

endmodule : gfs_status_bank
`default_nettype wire

/* File: test/gfs_ctrl_model.sv */
// Controller model issuing decoded frames
`timescale 1ns/1ps
`default_nettype none
module gfs_ctrl_model (
  input wire logic go,
  input wire logic rd,
  input wire logic [6:0] addr,
  output gfs_pkg::gfs_access_s access
);
  // Idle address inverted so no stale value looks valid
  assign access = '{go ? addr : ~addr, rd, go};
endmodule : gfs_ctrl_model
`default_nettype wire

/* File: test/gfs_status_bank_monitor.sv */
// Port checker of the fault status bank
`timescale 1ns/1ps
`default_nettype none
module gfs_status_bank_monitor (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Inputs of the bank
  input wire gfs_pkg::gfs_detect_s detect,
  input wire logic cycle_limit_enable,
  input wire logic cycle_counter_clear,
  input wire gfs_pkg::gfs_access_s access,
  // Outputs of the bank
  input wire logic [15:0] read_data,
  input wire logic read_hit,
  input wire logic cycle_counter_active,
  input wire logic summary_ds_overcurrent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd;
  assign rd = clk_en && access.valid && access.read_write_bit;
  sequence s_rd(n); rd && access.addr == n; endsequence
  // Read whose latched detector copy came from a clean, enabled edge
  sequence s_rd_settled(n);
    s_rd(n) && $past(clk_en) && $past(nrst);
  endsequence
  // Clear with no overcurrent detector rising against the latched copy
  sequence s_clear_quiet;
    clk_en && cycle_counter_clear && $past(clk_en) && $past(nrst) &&
    !(|(detect.drain_source_overcurrent &
        ~$past(detect.drain_source_overcurrent))) &&
    !(|(detect.sense_resistor_overcurrent &
        ~$past(detect.sense_resistor_overcurrent)));
  endsequence
  a_write_no_hit: assert property (clk_en && access.valid &&
    !access.read_write_bit |=> !read_hit && $stable(read_data))
    else $error("write moved");
  a_mapped_hit: assert property (rd && access.addr inside {[1:3]}
    |=> read_hit) else $error("no hit");
  a_unmapped_zero: assert property (rd && !(access.addr inside {[1:3]})
    |=> !read_hit && read_data == 16'h0000) else $error("bad miss");
  a_ovc_reserved: assert property (s_rd(7'h01) |=>
    read_data[14:11] == 4'h0 && read_data[7:6] == 2'h0) else $error("ovc");
  a_gate_reserved: assert property (s_rd(7'h02) |=>
    read_data[15:6] == 10'h000) else $error("gate");
  a_supply_reserved: assert property (s_rd(7'h03) |=>
    read_data[7:6] == 2'h0) else $error("supply");
  a_idle_counter: assert property (!cycle_limit_enable && clk_en
    |=> !cycle_counter_active) else $error("count");
  a_ds_flags: assert property (s_rd_settled(7'h01) |=>
    read_data[5:0] == $past(detect.drain_source_overcurrent, 2))
    else $error("ds");
  a_gate_flags: assert property (s_rd_settled(7'h02) |=>
    read_data[5:0] == $past(detect.gate_fault, 2)) else $error("gate map");
  a_active_bit: assert property (s_rd(7'h01) |=>
    read_data[15] == $past(cycle_counter_active)) else $error("active bit");
  a_summary_or: assert property (clk_en |=>
    summary_ds_overcurrent == |$past(detect.drain_source_overcurrent))
    else $error("summary");
  a_clear_idle: assert property (s_clear_quiet |=>
    !cycle_counter_active) else $error("clear");
endmodule : gfs_status_bank_monitor
bind gfs_status_bank gfs_status_bank_monitor mon (.clk, .nrst, .clk_en,
  .cycle_limit_enable, .read_hit, .cycle_counter_clear,
  .cycle_counter_active, .summary_ds_overcurrent, .detect, .access,
  .read_data);
`default_nettype wire

/* File: test/gfs_status_bank_tb_top.sv */
// Bench of the fault status bank
`timescale 1ns/1ps
`default_nettype none
module gfs_status_bank_tb_top;
  logic clk = 0, nrst = 0, go = 0, rw = 0, lim = 0, clr = 0, en = 1;
  logic hit, act, sum;
  logic [6:0] a = 7'h00;
  logic [15:0] rdata;
  gfs_pkg::gfs_detect_s det = '0;
  gfs_pkg::gfs_access_s acc;
  int errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  gfs_ctrl_model ctl (.go(go), .rd(rw), .addr(a), .access(acc));
  gfs_status_bank uut (.clk(clk), .nrst(nrst), .clk_en(en), .detect(det),
    .cycle_limit_enable(lim), .cycle_counter_clear(clr), .access(acc),
    .read_data(rdata), .read_hit(hit), .cycle_counter_active(act),
    .summary_ds_overcurrent(sum));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input logic [6:0] ad, input logic r, h,
    input logic [15:0] exp);
    @(negedge clk) {a, rw, go} = {ad, r, 1'b1};
    @(negedge clk) go = 0;
    chk("read_data", rdata, exp);
    chk("read_hit", {15'h0000, hit}, {15'h0000, h});
  endtask : rdchk
  task automatic t_fields;
    for (int i = 1; i < 4; i++) rdchk(i[6:0], 1, 1, 16'h0000);
    det = '{3'b100, 6'h23, 6'h16, 8'hA5, 6'h26};
    rdchk(7'h01, 1, 1, 16'h0423);
    rdchk(7'h02, 1, 1, 16'h0016);
    rdchk(7'h05, 1, 0, 16'h0000);
    rdchk(7'h03, 1, 1, 16'hA526);
    rdchk(7'h03, 0, 0, 16'hA526);
    chk("summary", {15'h0000, sum}, 16'h0001);
    $display("fields test end");
  endtask : t_fields
  task automatic t_count;
    det = '0;
    lim = 1;
    rdchk(7'h01, 1, 1, 16'h0000);
    det.drain_source_overcurrent = 6'h01;
    rdchk(7'h01, 1, 1, 16'h8001);
    clr = 1;
    @(negedge clk) clr = 0;
    rdchk(7'h01, 1, 1, 16'h0001);
    chk("active", {15'h0000, act}, 16'h0000);
    det.sense_resistor_overcurrent = 3'b010;
    clr = 1;
    @(negedge clk) clr = 0;
    chk("active", {15'h0000, act}, 16'h0001);
    rdchk(7'h01, 1, 1, 16'h8201);
    $display("counter test end");
  endtask : t_count
  task automatic t_freeze;
    @(negedge clk);
    en = 0;
    det.gate_fault = 6'h3F;
    rdchk(7'h02, 1, 0, 16'h8201);
    en = 1;
    rdchk(7'h02, 1, 1, 16'h003F);
    $display("freeze test end");
  endtask : t_freeze
  task automatic t_reset;
    @(negedge clk);
    nrst = 0;
    @(negedge clk);
    chk("rst read_data", rdata, 16'h0000);
    chk("rst flags", {13'h0000, hit, act, sum}, 16'h0000);
    nrst = 1;
    rdchk(7'h01, 1, 1, 16'h8201);
    $display("reset test end");
  endtask : t_reset
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1;
    t_fields();
    t_count();
    t_freeze();
    t_reset();
    print_verdict();
  end
  initial begin
    #5000;
    errors++;
    print_verdict();
  end
endmodule : gfs_status_bank_tb_top
`default_nettype wire
